// file: rtl/nusio_pkg.sv
// Package: register map, field codes and timing constants of the serial/pin IO
package nusio_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] NUSIO_PRI_DIV_OFS   = 8'h00;
	localparam logic [7:0] NUSIO_AUX_DIV_OFS   = 8'h04;
	localparam logic [7:0] NUSIO_MP_DIV_OFS    = 8'h08;
	localparam logic [7:0] NUSIO_FUNC_OFS      = 8'h0c;
	localparam logic [7:0] NUSIO_PRI_DATA_OFS  = 8'h10;
	localparam logic [7:0] NUSIO_AUX_DATA_OFS  = 8'h14;
	localparam logic [7:0] NUSIO_MP_DATA_OFS   = 8'h18;
	localparam logic [7:0] NUSIO_STATUS_OFS    = 8'h1c;
	localparam logic [7:0] NUSIO_PINOUT_OFS    = 8'h20;
	localparam logic [7:0] NUSIO_FREQ_OFS      = 8'h24;

	localparam int NUSIO_CLK_HZ        = 40_000_000;
	localparam int NUSIO_BAUD_DEFAULT  = 115_200;
	localparam int NUSIO_BAUD_MIN      = 4800;
	localparam int NUSIO_BAUD_MAX_FULL = 4_000_000;
	localparam int NUSIO_BAUD_MAX_MP   = 250_000;
	localparam int NUSIO_BITS_PER_CHAR = 10;
	localparam int NUSIO_DATA_BITS     = 8;
	localparam int NUSIO_PULSE_MS      = 100;
	localparam int NUSIO_SECOND_MS     = 1000;

	localparam int NUSIO_DIV_W = 16;
	// Clocks per bit, rounded down: the rate is nominal either way
	localparam logic [15:0] NUSIO_DIV_DEFAULT =
		16'(NUSIO_CLK_HZ / NUSIO_BAUD_DEFAULT);
	localparam logic [15:0] NUSIO_DIV_MIN_FULL =
		16'(NUSIO_CLK_HZ / NUSIO_BAUD_MAX_FULL);
	localparam logic [15:0] NUSIO_DIV_MIN_MP =
		16'(NUSIO_CLK_HZ / NUSIO_BAUD_MAX_MP);
	localparam logic [15:0] NUSIO_DIV_MAX =
		16'(NUSIO_CLK_HZ / NUSIO_BAUD_MIN);
	localparam int NUSIO_PULSE_CYC  = NUSIO_CLK_HZ / 1000 * NUSIO_PULSE_MS;
	localparam int NUSIO_SECOND_CYC = NUSIO_CLK_HZ / 1000 * NUSIO_SECOND_MS;

	// Function field layout in the FUNC register
	localparam int NUSIO_FN_W      = 3;
	localparam int NUSIO_FN1_LSB   = 0;
	localparam int NUSIO_FN2_LSB   = 4;
	localparam int NUSIO_FNA_LSB   = 8;
	localparam logic [31:0] NUSIO_FUNC_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		NUSIO_FN_INACTIVE = 3'h0,
		NUSIO_FN_DIN      = 3'h1,
		NUSIO_FN_DOUT     = 3'h2,
		NUSIO_FN_FIN      = 3'h3,
		NUSIO_FN_FOUT     = 3'h4,
		NUSIO_FN_SERIAL   = 3'h5
	} nusio_fn_t;

	// Status bit positions
	localparam int NUSIO_ST_TIME_INIT = 0;
	localparam int NUSIO_ST_PRI_RXV   = 1;
	localparam int NUSIO_ST_AUX_RXV   = 2;
	localparam int NUSIO_ST_MP_RXV    = 3;
	localparam int NUSIO_ST_PRI_TXB   = 4;
	localparam int NUSIO_ST_AUX_TXB   = 5;
	localparam int NUSIO_ST_MP_TXB    = 6;
	localparam int NUSIO_ST_DIV_ERR   = 7;
	localparam int NUSIO_ST_PIN1_IN   = 8;
	localparam int NUSIO_ST_PIN2_IN   = 9;
endpackage

// file: rtl/nusio_port_if.sv
// Interface: one serial port's byte and line signals
interface nusio_port_if;
	logic [15:0] div;
	logic        div_load;
	logic [7:0]  tx_data;
	logic        tx_start;
	logic        tx_busy;
	logic        tx_line;
	logic        rx_line;
	logic [7:0]  rx_data;
	logic        rx_valid;
	modport ctrl (output div, div_load, tx_data, tx_start, rx_line,
		input tx_busy, tx_line, rx_data, rx_valid);
	modport uart (input div, div_load, tx_data, tx_start, rx_line,
		output tx_busy, tx_line, rx_data, rx_valid);
endinterface

// file: rtl/nusio_uart.sv
// One 8N1 serial port with loadable bit divisor
module nusio_uart
	import nusio_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Port
	nusio_port_if.uart p
);
	logic [15:0] div_r;
	logic [15:0] tcnt_r;
	logic [3:0]  tbit_r;
	logic [9:0]  tsh_r;
	logic        tbusy_r;
	logic [15:0] rcnt_r;
	logic [3:0]  rbit_r;
	logic [7:0]  rsh_r;
	logic        rbusy_r;
	logic [7:0]  rdat_r;
	logic        rval_r;

	wire t_tick = (tcnt_r == 16'h0000);
	wire r_tick = (rcnt_r == 16'h0000);
	assign p.tx_busy  = tbusy_r;
	assign p.tx_line  = tbusy_r ? tsh_r[0] : 1'b1;
	assign p.rx_data  = rdat_r;
	assign p.rx_valid = rval_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_r <= NUSIO_DIV_DEFAULT;
		end else if (p.div_load) begin
			div_r <= p.div;
		end
	end

	// Transmit: start, 8 data LSB first, stop; start while busy is dropped
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tbusy_r <= 1'b0;
			tsh_r   <= 10'h3ff;
			tcnt_r  <= 16'h0000;
			tbit_r  <= 4'h0;
		end else if (!tbusy_r) begin
			if (p.tx_start) begin
				tbusy_r <= 1'b1;
				tsh_r   <= {1'b1, p.tx_data, 1'b0};
				tcnt_r  <= div_r - 16'h0001;
				tbit_r  <= 4'h0;
			end
		end else if (t_tick) begin
			tcnt_r <= div_r - 16'h0001;
			tsh_r  <= {1'b1, tsh_r[9:1]};
			if (tbit_r == 4'(NUSIO_BITS_PER_CHAR - 1)) begin
				tbusy_r <= 1'b0;
			end
			tbit_r <= tbit_r + 4'h1;
		end else begin
			tcnt_r <= tcnt_r - 16'h0001;
		end
	end

	// Receive: sample mid-bit, a low stop bit discards the character
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rbusy_r <= 1'b0;
			rcnt_r  <= 16'h0000;
			rbit_r  <= 4'h0;
			rsh_r   <= 8'h00;
			rdat_r  <= 8'h00;
			rval_r  <= 1'b0;
		end else begin
			rval_r <= 1'b0;
			if (!rbusy_r) begin
				if (!p.rx_line) begin
					rbusy_r <= 1'b1;
					rcnt_r  <= {1'b0, div_r[15:1]};
					rbit_r  <= 4'h0;
				end
			end else if (r_tick) begin
				rcnt_r <= div_r - 16'h0001;
				rbit_r <= rbit_r + 4'h1;
				if (rbit_r == 4'h0) begin
					if (p.rx_line) begin
						rbusy_r <= 1'b0;
					end
				end else if (rbit_r <= 4'(NUSIO_DATA_BITS)) begin
					rsh_r <= {p.rx_line, rsh_r[7:1]};
				end else begin
					rbusy_r <= 1'b0;
					if (p.rx_line) begin
						rdat_r <= rsh_r;
						rval_r <= 1'b1;
					end
				end
			end else begin
				rcnt_r <= rcnt_r - 16'h0001;
			end
		end
	end

	property p_tx_start_bit;
		@(posedge clk) disable iff (reset)
		(!tbusy_r && p.tx_start) |=> (p.tx_line == 1'b0);
	endproperty
	a_tx_start_bit: assert property (p_tx_start_bit)
		else $error("start bit not driven low");

	property p_tx_idle_high;
		@(posedge clk) disable iff (reset)
		!tbusy_r |-> p.tx_line;
	endproperty
	a_tx_idle_high: assert property (p_tx_idle_high)
		else $error("idle line not high");
endmodule // nusio_uart

// file: rtl/nusio_top.sv
// Serial ports, multi-function pins and second pulse of the nav unit IO
//Operation
// - All ports start at 115200 baud until software writes a divisor.
// - Primary and auxiliary ports accept 4800 to 4000000 baud.
// - Multi-pin serial port accepts 4800 to 250000 baud.
// - Characters are fixed 8N1: start, eight data, stop, no parity.
// - One character takes ten bit times, so bytes/s is baud/10.
// - A byte written while transmitter is busy is dropped silently.
// - Second pulse rests low, high 100 ms at each second start after the first.
// - Software reads a time-initialised flag for second pulse validity.
// - Primary port carries only the packet protocol, no pin functions.
// - Auxiliary port has pin functions; multi-pin port is RS232 only.
// - In serial mode pin one transmits and pin two receives.
// - Each multi pin offers digital input, digital output and frequency output; frequency input only releases the pin.
// - Function changes take effect at once, no restart needed.
// - A serial function switches that pin's driver to RS232 level.
// - Inactive function puts the pin in high impedance.
module nusio_top
	import nusio_pkg::*;
#(
	parameter int SECOND_CYC = NUSIO_SECOND_CYC,
	parameter int PULSE_CYC  = NUSIO_PULSE_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Primary port
	output logic             pri_txd,
	input  wire logic        pri_rxd,
	// Auxiliary port
	output logic             aux_tx_o,
	output logic             aux_tx_oe,
	input  wire logic        aux_rx_i,
	output logic             aux_rs232,
	// Multi-function pins
	input  wire logic        multi_pin_one_i,
	output logic             multi_pin_one_o,
	output logic             multi_pin_one_oe,
	output logic             multi_pin_one_rs232,
	input  wire logic        multi_pin_two_i,
	output logic             multi_pin_two_o,
	output logic             multi_pin_two_oe,
	output logic             multi_pin_two_rs232,
	// Timing
	input  wire logic        time_valid,
	output logic             second_pulse
);
	// A pulse as long as the second would never fall between seconds
	if (PULSE_CYC < 1 || PULSE_CYC >= SECOND_CYC) begin : g_bad_pulse
		$error("pulse must be shorter than the second");
	end

	nusio_port_if pri_if ();
	nusio_port_if aux_if ();
	nusio_port_if mp_if ();

	logic [31:0] func_r;
	logic [15:0] pri_div_r;
	logic [15:0] aux_div_r;
	logic [15:0] mp_div_r;
	logic        div_err_r;
	logic [1:0]  pin_out_r;
	logic [15:0] freq_div_r;
	logic [15:0] fcnt_r;
	logic        ftog_r;
	logic [31:0] sec_cnt_r;
	logic        pulse_r;
	logic        time_init_r;
	logic [2:0]  rxv_r;
	logic [7:0]  rx_pri_r;
	logic [7:0]  rx_aux_r;
	logic [7:0]  rx_mp_r;
	logic [1:0]  pin_in_r;
	logic [31:0] rdata_r;

	function automatic logic div_ok(input logic [15:0] d,
		input logic [15:0] lo);
		return (d >= lo) && (d <= NUSIO_DIV_MAX);
	endfunction

	wire nusio_fn_t fn1 = nusio_fn_t'(func_r[NUSIO_FN1_LSB +: NUSIO_FN_W]);
	wire nusio_fn_t fn2 = nusio_fn_t'(func_r[NUSIO_FN2_LSB +: NUSIO_FN_W]);
	wire nusio_fn_t fna = nusio_fn_t'(func_r[NUSIO_FNA_LSB +: NUSIO_FN_W]);
	wire mp_serial  = (fn1 == NUSIO_FN_SERIAL) && (fn2 == NUSIO_FN_SERIAL);
	wire aux_serial = (fna == NUSIO_FN_SERIAL);

	wire wr_pri_div = reg_wr && (reg_addr == NUSIO_PRI_DIV_OFS);
	wire wr_aux_div = reg_wr && (reg_addr == NUSIO_AUX_DIV_OFS);
	wire wr_mp_div  = reg_wr && (reg_addr == NUSIO_MP_DIV_OFS);
	wire wr_func    = reg_wr && (reg_addr == NUSIO_FUNC_OFS);
	wire wr_pri_dat = reg_wr && (reg_addr == NUSIO_PRI_DATA_OFS);
	wire wr_aux_dat = reg_wr && (reg_addr == NUSIO_AUX_DATA_OFS);
	wire wr_mp_dat  = reg_wr && (reg_addr == NUSIO_MP_DATA_OFS);
	wire wr_pinout  = reg_wr && (reg_addr == NUSIO_PINOUT_OFS);
	wire wr_freq    = reg_wr && (reg_addr == NUSIO_FREQ_OFS);
	wire rd_pri_dat = reg_rd && (reg_addr == NUSIO_PRI_DATA_OFS);
	wire rd_aux_dat = reg_rd && (reg_addr == NUSIO_AUX_DATA_OFS);
	wire rd_mp_dat  = reg_rd && (reg_addr == NUSIO_MP_DATA_OFS);
	wire [15:0] wdiv = reg_wdata[15:0];
	wire pri_ok = div_ok(wdiv, NUSIO_DIV_MIN_FULL);
	wire mp_ok  = div_ok(wdiv, NUSIO_DIV_MIN_MP);

	// Ports: an out-of-range divisor is refused and flagged
	assign pri_if.div      = wdiv;
	assign pri_if.div_load = wr_pri_div && pri_ok;
	assign aux_if.div      = wdiv;
	assign aux_if.div_load = wr_aux_div && pri_ok;
	assign mp_if.div       = wdiv;
	assign mp_if.div_load  = wr_mp_div && mp_ok;
	assign pri_if.tx_data  = reg_wdata[7:0];
	assign aux_if.tx_data  = reg_wdata[7:0];
	assign mp_if.tx_data   = reg_wdata[7:0];
	// A write while busy is simply lost, with no indication
	assign pri_if.tx_start = wr_pri_dat;
	assign aux_if.tx_start = wr_aux_dat && aux_serial;
	assign mp_if.tx_start  = wr_mp_dat && mp_serial;
	assign pri_if.rx_line  = pri_rxd;
	assign aux_if.rx_line  = aux_serial ? aux_rx_i : 1'b1;
	assign mp_if.rx_line   = mp_serial ? multi_pin_two_i : 1'b1;

	nusio_uart u_pri (.clk(clk), .reset(reset), .p(pri_if.uart));
	nusio_uart u_aux (.clk(clk), .reset(reset), .p(aux_if.uart));
	nusio_uart u_mp  (.clk(clk), .reset(reset), .p(mp_if.uart));

	assign pri_txd = pri_if.tx_line;

	// Auxiliary lines: serial, driven level (also codes 6, 7) or frequency output, else high impedance
	assign aux_tx_oe = (fna != NUSIO_FN_INACTIVE) && (fna != NUSIO_FN_DIN)
		&& (fna != NUSIO_FN_FIN);
	assign aux_tx_o  = aux_serial ? aux_if.tx_line :
		(fna == NUSIO_FN_FOUT) ? ftog_r : pin_out_r[0];
	assign aux_rs232 = 1'b1;

	// Multi pins: function decode is combinational, so a change acts now
	assign multi_pin_one_oe = (fn1 == NUSIO_FN_DOUT) ||
		(fn1 == NUSIO_FN_FOUT) || mp_serial;
	assign multi_pin_one_o  = mp_serial ? mp_if.tx_line :
		(fn1 == NUSIO_FN_FOUT) ? ftog_r : pin_out_r[0];
	assign multi_pin_two_oe = !mp_serial && ((fn2 == NUSIO_FN_DOUT) ||
		(fn2 == NUSIO_FN_FOUT));
	assign multi_pin_two_o  = (fn2 == NUSIO_FN_FOUT) ? ftog_r :
		pin_out_r[1];
	assign multi_pin_one_rs232 = (fn1 == NUSIO_FN_SERIAL);
	assign multi_pin_two_rs232 = (fn2 == NUSIO_FN_SERIAL);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			func_r <= NUSIO_FUNC_RESET;
		end else if (wr_func) begin
			func_r <= reg_wdata;
		end
	end

	// Shadow copies of the divisors for read-back and refused writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pri_div_r <= NUSIO_DIV_DEFAULT;
			aux_div_r <= NUSIO_DIV_DEFAULT;
			mp_div_r  <= NUSIO_DIV_DEFAULT;
			div_err_r <= 1'b0;
		end else begin
			if (pri_if.div_load) begin
				pri_div_r <= wdiv;
			end
			if (aux_if.div_load) begin
				aux_div_r <= wdiv;
			end
			if (mp_if.div_load) begin
				mp_div_r <= wdiv;
			end
			if ((wr_pri_div || wr_aux_div) && !pri_ok ||
				wr_mp_div && !mp_ok) begin
				div_err_r <= 1'b1;
			end else if (wr_pri_div || wr_aux_div || wr_mp_div) begin
				div_err_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_out_r  <= 2'b00;
			freq_div_r <= 16'h0000;
		end else begin
			if (wr_pinout) begin
				pin_out_r <= reg_wdata[1:0];
			end
			if (wr_freq) begin
				freq_div_r <= reg_wdata[15:0];
			end
		end
	end

	// Frequency output: toggles every freq_div+1 cycles
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fcnt_r <= 16'h0000;
			ftog_r <= 1'b0;
		end else if (fcnt_r >= freq_div_r) begin
			fcnt_r <= 16'h0000;
			ftog_r <= !ftog_r;
		end else begin
			fcnt_r <= fcnt_r + 16'h0001;
		end
	end

	// Second pulse: high for the first PULSE_CYC cycles of every second after the first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sec_cnt_r <= 32'h0000_0000;
			pulse_r   <= 1'b0;
		end else begin
			if (sec_cnt_r == 32'(SECOND_CYC - 1)) begin
				sec_cnt_r <= 32'h0000_0000;
				pulse_r   <= 1'b1;
			end else begin
				sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
				if (sec_cnt_r == 32'(PULSE_CYC - 1)) begin
					pulse_r <= 1'b0;
				end
			end
		end
	end
	assign second_pulse = pulse_r;

	// Received bytes held until read; a new byte wins over the read clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rxv_r       <= 3'b000;
			rx_pri_r    <= 8'h00;
			rx_aux_r    <= 8'h00;
			rx_mp_r     <= 8'h00;
			time_init_r <= 1'b0;
			pin_in_r    <= 2'b00;
		end else begin
			time_init_r <= time_valid;
			pin_in_r    <= {multi_pin_two_i, multi_pin_one_i};
			if (pri_if.rx_valid) begin
				rx_pri_r <= pri_if.rx_data;
			end
			if (aux_if.rx_valid) begin
				rx_aux_r <= aux_if.rx_data;
			end
			if (mp_if.rx_valid) begin
				rx_mp_r <= mp_if.rx_data;
			end
			rxv_r[0] <= pri_if.rx_valid || (rxv_r[0] && !rd_pri_dat);
			rxv_r[1] <= aux_if.rx_valid || (rxv_r[1] && !rd_aux_dat);
			rxv_r[2] <= mp_if.rx_valid || (rxv_r[2] && !rd_mp_dat);
		end
	end

	logic [31:0] status_w;
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[NUSIO_ST_TIME_INIT] = time_init_r;
		status_w[NUSIO_ST_PRI_RXV]   = rxv_r[0];
		status_w[NUSIO_ST_AUX_RXV]   = rxv_r[1];
		status_w[NUSIO_ST_MP_RXV]    = rxv_r[2];
		status_w[NUSIO_ST_PRI_TXB]   = pri_if.tx_busy;
		status_w[NUSIO_ST_AUX_TXB]   = aux_if.tx_busy;
		status_w[NUSIO_ST_MP_TXB]    = mp_if.tx_busy;
		status_w[NUSIO_ST_DIV_ERR]   = div_err_r;
		status_w[NUSIO_ST_PIN1_IN]   = pin_in_r[0];
		status_w[NUSIO_ST_PIN2_IN]   = pin_in_r[1];
	end

	logic [31:0] rsel;
	always_comb begin
		unique case (reg_addr)
			NUSIO_PRI_DIV_OFS:  rsel = {16'h0000, pri_div_r};
			NUSIO_AUX_DIV_OFS:  rsel = {16'h0000, aux_div_r};
			NUSIO_MP_DIV_OFS:   rsel = {16'h0000, mp_div_r};
			NUSIO_FUNC_OFS:     rsel = func_r;
			NUSIO_PRI_DATA_OFS: rsel = {24'h000000, rx_pri_r};
			NUSIO_AUX_DATA_OFS: rsel = {24'h000000, rx_aux_r};
			NUSIO_MP_DATA_OFS:  rsel = {24'h000000, rx_mp_r};
			NUSIO_STATUS_OFS:   rsel = status_w;
			NUSIO_PINOUT_OFS:   rsel = {30'h0, pin_out_r};
			NUSIO_FREQ_OFS:     rsel = {16'h0000, freq_div_r};
			default:            rsel = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= reg_rd ? rsel : 32'h0000_0000;
		end
	end
	assign reg_rdata = rdata_r;

	property p_pulse_rise;
		@(posedge clk) disable iff (reset)
		$rose(pulse_r) |-> (sec_cnt_r == 32'h0000_0000);
	endproperty
	a_pulse_rise: assert property (p_pulse_rise)
		else $error("second pulse rose off the second boundary");

	property p_pulse_len;
		@(posedge clk) disable iff (reset)
		pulse_r |-> (sec_cnt_r < 32'(PULSE_CYC));
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("second pulse too long");

	property p_reset_inactive;
		@(posedge clk) disable iff (reset)
		(func_r == NUSIO_FUNC_RESET) |-> !multi_pin_one_oe &&
			!multi_pin_two_oe && !aux_tx_oe;
	endproperty
	a_reset_inactive: assert property (p_reset_inactive)
		else $error("pin driven while inactive");

	property p_func_now;
		@(posedge clk) disable iff (reset)
		(wr_func && reg_wdata[NUSIO_FN1_LSB +: NUSIO_FN_W] == 3'h2)
			|=> multi_pin_one_oe;
	endproperty
	a_func_now: assert property (p_func_now)
		else $error("function change late");

	property p_rs232;
		@(posedge clk) disable iff (reset)
		mp_serial |-> multi_pin_one_rs232 && multi_pin_two_rs232 &&
			!multi_pin_two_oe;
	endproperty
	a_rs232: assert property (p_rs232)
		else $error("serial pins not at line level");

	property p_mp_range;
		@(posedge clk) disable iff (reset)
		(wr_mp_div && wdiv < NUSIO_DIV_MIN_MP) |=> $stable(mp_div_r);
	endproperty
	a_mp_range: assert property (p_mp_range)
		else $error("multi-pin divisor too fast accepted");

	property p_full_range;
		@(posedge clk) disable iff (reset)
		(wr_pri_div && pri_ok) |=> (pri_div_r == $past(wdiv));
	endproperty
	a_full_range: assert property (p_full_range)
		else $error("valid primary divisor not loaded");

	property p_time_flag;
		@(posedge clk) disable iff (reset)
		time_valid |=> status_w[NUSIO_ST_TIME_INIT];
	endproperty
	a_time_flag: assert property (p_time_flag)
		else $error("time flag not shown");
endmodule // nusio_top

// file: verification/nusio_host_model.sv
// Host side model: 8N1 receiver and transmitter for the primary port
module nusio_host_model #(
	parameter int BIT_CYC = 10
) (
	input  wire logic clk,
	input  wire logic rx_line,
	output logic      tx_line
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] rx_q[$];
	int         frame_err;
	logic [7:0] sh;

	initial begin
		tx_line = 1'b1;
		frame_err = 0;
	end

	// Mid-bit sampling keeps a divisor rounded down inside the bit window
	always begin
		@(negedge rx_line);
		repeat (BIT_CYC / 2) @(posedge clk);
		if (rx_line == 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk);
				sh[i] = rx_line;
			end
			repeat (BIT_CYC) @(posedge clk);
			if (rx_line !== 1'b1)
				frame_err++;
			else
				rx_q.push_back(sh);
		end
	end

	// Line changes only right after an edge; idle mark level between frames
	task automatic send(input logic [7:0] b);
		@(posedge clk);
		tx_line <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge clk);
			tx_line <= b[i];
		end
		repeat (BIT_CYC) @(posedge clk);
		tx_line <= 1'b1;
		repeat (BIT_CYC) @(posedge clk);
	endtask
endmodule // nusio_host_model

// file: verification/test_nav_unit_serial_and_pin_io.sv
// Self-checking bench for the serial ports, pins and second pulse
module test_nav_unit_serial_and_pin_io;
	timeunit 1ns;
	timeprecision 1ps;
	import nusio_pkg::*;

	localparam int SEC = 100;
	localparam int PUL = 10;
	localparam int BIT = 10;

	logic        clk, reset, reg_wr, reg_rd, pri_rxd, time_valid;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic        pri_txd, aux_tx_o, aux_tx_oe, aux_rs232, second_pulse;
	logic        p1_i, p1_o, p1_oe, p1_rs, p2_i, p2_o, p2_oe, p2_rs;
	int          failures, checks, n;

	nusio_top #(.SECOND_CYC(SEC), .PULSE_CYC(PUL)) nusio_top_inst (
		.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pri_txd(pri_txd), .pri_rxd(pri_rxd),
		.aux_tx_o(aux_tx_o), .aux_tx_oe(aux_tx_oe), .aux_rx_i(pri_rxd),
		.aux_rs232(aux_rs232), .multi_pin_one_i(p1_i),
		.multi_pin_one_o(p1_o), .multi_pin_one_oe(p1_oe),
		.multi_pin_one_rs232(p1_rs), .multi_pin_two_i(p2_i),
		.multi_pin_two_o(p2_o), .multi_pin_two_oe(p2_oe),
		.multi_pin_two_rs232(p2_rs), .time_valid(time_valid),
		.second_pulse(second_pulse));

	nusio_host_model #(.BIT_CYC(BIT)) nusio_host_model_inst (
		.clk(clk), .rx_line(pri_txd), .tx_line(pri_rxd));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		// Data stand for the cycle after the strobe; taken at its end
		@(posedge clk);
		d = reg_rdata;
	endtask

	task automatic t_reset;
		rd(NUSIO_PRI_DIV_OFS, v);
		chk("pri div", v, 32'(NUSIO_DIV_DEFAULT));
		rd(NUSIO_MP_DIV_OFS, v);
		chk("multi div", v, 32'(NUSIO_DIV_DEFAULT));
		rd(NUSIO_FUNC_OFS, v);
		chk("func", v, NUSIO_FUNC_RESET);
		chk("oes", {p1_oe, p2_oe, aux_tx_oe}, 3'h0);
		rd(8'h80, v);
		chk("unmapped", v, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_div;
		wr(NUSIO_PRI_DIV_OFS, 32'h9);
		rd(NUSIO_STATUS_OFS, v);
		chk("div err", v[NUSIO_ST_DIV_ERR], 1'b1);
		rd(NUSIO_PRI_DIV_OFS, v);
		chk("pri div kept", v, 32'(NUSIO_DIV_DEFAULT));
		wr(NUSIO_MP_DIV_OFS, 32'(NUSIO_DIV_MIN_MP) - 1);
		rd(NUSIO_MP_DIV_OFS, v);
		chk("multi div kept", v, 32'(NUSIO_DIV_DEFAULT));
		wr(NUSIO_MP_DIV_OFS, 32'(NUSIO_DIV_MIN_MP));
		rd(NUSIO_MP_DIV_OFS, v);
		chk("multi div min", v, 32'(NUSIO_DIV_MIN_MP));
		wr(NUSIO_PRI_DIV_OFS, 32'(BIT));
		rd(NUSIO_STATUS_OFS, v);
		chk("div err clr", v[NUSIO_ST_DIV_ERR], 1'b0);
		$display("test divisor done");
	endtask

	task automatic t_tx;
		wr(NUSIO_PRI_DATA_OFS, 32'ha5);
		rd(NUSIO_STATUS_OFS, v);
		chk("busy early", v[NUSIO_ST_PRI_TXB], 1'b1);
		repeat (85) @(posedge clk);
		rd(NUSIO_STATUS_OFS, v);
		chk("busy late", v[NUSIO_ST_PRI_TXB], 1'b1);
		repeat (15) @(posedge clk);
		rd(NUSIO_STATUS_OFS, v);
		chk("busy end", v[NUSIO_ST_PRI_TXB], 1'b0);
		wr(NUSIO_PRI_DATA_OFS, 32'h3c);
		wr(NUSIO_PRI_DATA_OFS, 32'h77);
		repeat (250) @(posedge clk);
		n = nusio_host_model_inst.rx_q.size();
		chk("tx count", 32'(n), 32'h2);
		if (n == 2) begin
			chk("tx byte", nusio_host_model_inst.rx_q[0], 8'ha5);
			chk("tx next", nusio_host_model_inst.rx_q[1], 8'h3c);
		end
		chk("frame", 32'(nusio_host_model_inst.frame_err), 32'h0);
		$display("test transmit done");
	endtask

	task automatic t_rx;
		nusio_host_model_inst.send(8'h5a);
		rd(NUSIO_STATUS_OFS, v);
		chk("rx valid", v[NUSIO_ST_PRI_RXV], 1'b1);
		rd(NUSIO_PRI_DATA_OFS, v);
		chk("rx data", v[7:0], 8'h5a);
		rd(NUSIO_STATUS_OFS, v);
		chk("rx clr", v[NUSIO_ST_PRI_RXV], 1'b0);
		wr(NUSIO_AUX_DIV_OFS, 32'(BIT));
		wr(NUSIO_FUNC_OFS, 32'h500);
		nusio_host_model_inst.send(8'hc3);
		rd(NUSIO_AUX_DATA_OFS, v);
		chk("aux rx", v[7:0], 8'hc3);
		$display("test receive done");
	endtask

	task automatic t_func;
		logic drv;
		for (int f = 1; f < 5; f++) begin
			drv = (f == 2 || f == 4);
			wr(NUSIO_FUNC_OFS, 32'(f) | 32'(f) << 8);
			@(posedge clk);
			chk("pin oe", {p1_oe, aux_tx_oe}, {drv, drv});
			chk("pin lvl", p1_rs, 1'b0);
		end
		wr(NUSIO_PINOUT_OFS, 32'h2);
		wr(NUSIO_FUNC_OFS, 32'h222);
		@(posedge clk);
		chk("pin out", {p1_o, p2_o, p2_oe, aux_tx_o, aux_rs232}, 5'h0d);
		chk("aux lvl", aux_rs232, 1'b1);
		wr(NUSIO_FUNC_OFS, 32'h11);
		p1_i <= 1'b1;
		p2_i <= 1'b0;
		repeat (4) @(posedge clk);
		rd(NUSIO_STATUS_OFS, v);
		chk("pin in", v[NUSIO_ST_PIN2_IN:NUSIO_ST_PIN1_IN], 2'h1);
		wr(NUSIO_FUNC_OFS, 32'h55);
		wr(NUSIO_MP_DATA_OFS, 32'h81);
		@(posedge clk);
		chk("serial start", p1_o, 1'b0);
		chk("serial oe", {p1_oe, p2_oe}, 2'h2);
		chk("serial lvl", {p1_rs, p2_rs}, 2'h3);
		chk("aux idle", aux_tx_oe, 1'b0);
		wr(NUSIO_FUNC_OFS, 32'h0);
		@(posedge clk);
		chk("inactive", {p1_oe, p2_oe, p1_rs, p2_rs}, 4'h0);
		$display("test functions done");
	endtask

	task automatic t_pulse;
		time_valid <= 1'b1;
		repeat (3) @(posedge clk);
		rd(NUSIO_STATUS_OFS, v);
		chk("time init", v[NUSIO_ST_TIME_INIT], 1'b1);
		n = 0;
		while (second_pulse !== 1'b0 && n < 2 * SEC) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (second_pulse !== 1'b1 && n < 2 * SEC) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (second_pulse === 1'b1 && n < 2 * SEC) begin
			@(posedge clk);
			n++;
		end
		chk("pulse high", 32'(n), 32'(PUL));
		while (second_pulse !== 1'b1 && n < 3 * SEC) begin
			@(posedge clk);
			n++;
		end
		chk("pulse period", 32'(n), 32'(SEC));
		$display("test second pulse done");
	endtask

	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		failures = 0;
		checks = 0;
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		time_valid = 1'b0;
		p1_i = 1'b0;
		p2_i = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		chk("idle tx", {pri_txd, second_pulse}, 2'h2);
		t_reset;
		t_div;
		t_tx;
		t_rx;
		t_func;
		t_pulse;
		summarize;
	end

	// Whole sequence needs about 800 cycles
	initial begin
		#(25 * 20000);
		failures++;
		summarize;
	end
endmodule // test_nav_unit_serial_and_pin_io
